// ==== ara_pkg.sv ====
// package for the converter result accumulator: offsets, reset values, codes and the
// register carrier. assumes an sfr-style byte bus and a 12-bit conversion core outside.
package ara_pkg;
  localparam logic [7:0] ARA_CFG_ADDR    = 8'hBC;
  localparam logic [7:0] ARA_LOW_ADDR    = 8'hBD;
  localparam logic [7:0] ARA_HIGH_ADDR   = 8'hBE;
  localparam logic [7:0] ARA_CTRL_ADDR   = 8'hE8;
  localparam logic [7:0] ARA_CFG_RESET   = 8'hF8;
  localparam logic [7:0] ARA_CTRL_RESET  = 8'h00;
  localparam logic [7:0] ARA_DATA_RESET  = 8'h00;
  localparam int         ARA_CFG_GAIN_BIT = 0;
  localparam int         ARA_CFG_RPT_LSB  = 1;
  localparam int         ARA_CTRL_LJST_BIT  = 2;
  localparam int         ARA_CTRL_WIN_BIT   = 3;
  localparam int         ARA_CTRL_BUSY_BIT  = 4;
  localparam int         ARA_CTRL_DONE_BIT  = 5;
  localparam int         ARA_CTRL_BURST_BIT = 6;
  localparam logic [1:0] ARA_RPT_1  = 2'h0;
  localparam logic [1:0] ARA_RPT_4  = 2'h1;
  localparam logic [1:0] ARA_RPT_8  = 2'h2;
  localparam logic [1:0] ARA_RPT_16 = 2'h3;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ara_bus_type;
endpackage

// ==== ara_format.sv ====
// output formatter: turns a 16-bit accumulated sum into the high/low data byte pair.
// assumes the sum is already final and the repeat code matches the sum it came from.
`timescale 1ns/1ps
module ara_format (
  input  wire logic [15:0] sum,
  input  wire logic [1:0]  rpt,
  input  wire logic        ljst,
  output logic      [7:0]  high_byte,
  output logic      [7:0]  low_byte
);
  always_comb begin
    high_byte = 8'h00;
    low_byte  = sum[7:0];
    if (ljst) begin
      high_byte = sum[11:4];
      low_byte  = {sum[3:0], 4'h0};
    end else begin
      low_byte = sum[7:0];
      unique case (rpt)
        ara_pkg::ARA_RPT_1:  high_byte = {4'h0, sum[11:8]};
        ara_pkg::ARA_RPT_4:  high_byte = {3'h0, sum[12:8]};
        ara_pkg::ARA_RPT_8:  high_byte = {2'h0, sum[13:8]};
        ara_pkg::ARA_RPT_16: high_byte = sum[15:8];
      endcase
    end
  end
endmodule

// ==== ara_top.sv ====
// What this block does
// - repeat code 00/01/10/11 selects 1, 4, 8 or 16 accumulated conversions.
// - done and window events fire only after the whole set.
// - burst off: one trigger starts one conversion of the set.
// - burst on: one trigger runs the whole set back to back.
// - every conversion result is summed into the data byte pair.
// - configuration bit 0 is the gain programming enable.
// - right, code 00: high byte bits 3-0 hold result top four bits.
// - right, code 01: high byte bits 4-0 hold bits 12-8 of the 14-bit sum.
// - right, code 10: high byte bits 5-0 hold bits 13-8 of the 15-bit sum.
// - right, code 11: high byte holds top eight bits of 16-bit sum.
// - left justified: high byte holds top eight result bits.
// - right justified: low byte holds lowest eight sum bits.
// - left justified: low byte bits 7-4 hold low result bits, rest zero.
// - justification bit 0 selects right, 1 selects left.
// - burst bit 0 is off, 1 is on.
//
// top of the result accumulator: sfr byte registers, set sequencing, accumulation.
// assumes the analog core answers each start with one conv_valid pulse and a 12-bit code,
// and that the window comparison outside is sampled with the last conv_valid of a set.
`timescale 1ns/1ps
module ara_top #(
  parameter int RES_W = 12
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire ara_pkg::ara_bus_type bus,
  output logic [7:0]               rdata,
  input  wire logic                start_trig,
  output logic                     conv_start,
  input  wire logic                conv_valid,
  input  wire logic [RES_W-1:0]    conv_code,
  input  wire logic                window_hit,
  output logic                     conv_done_event,
  output logic                     window_cmp_event,
  output logic                     gain_prog_enable,
  output logic [15:0]              gain_write_word,
  output logic                     gain_write
);
  typedef enum logic [2:0] {
    ARA_IDLE = 3'b001,
    ARA_CONV = 3'b010,
    ARA_WAIT = 3'b100
  } ara_state_type;

  ara_state_type state_r, state_nxt;
  logic [7:0]  cfg_r, cfg_nxt;
  logic [7:0]  ctrl_r, ctrl_nxt;
  logic [7:0]  high_r, high_nxt;
  logic [7:0]  low_r, low_nxt;
  logic [15:0] acc_r, acc_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [1:0]  rpt_r, rpt_nxt;
  logic        ljst_r, ljst_nxt;
  logic        done_r, done_nxt;
  logic        win_r, win_nxt;
  logic        start_r, start_nxt;
  logic [3:0]  last_idx;
  logic [15:0] sum_now;
  logic [7:0]  fmt_high;
  logic [7:0]  fmt_low;
  logic        burst;
  logic        trig;

  // burst is read live: clearing it mid-set falls back to one trigger per conversion
  // burst bit level
  assign burst = ctrl_r[ara_pkg::ARA_CTRL_BURST_BIT];
  // software start writes busy high; the hardware source may also trigger
  assign trig = start_trig |
                (bus.wr && bus.addr == ara_pkg::ARA_CTRL_ADDR && bus.wdata[ara_pkg::ARA_CTRL_BUSY_BIT]);
  assign gain_prog_enable = cfg_r[ara_pkg::ARA_CFG_GAIN_BIT];
  assign conv_start       = start_r;
  assign conv_done_event  = done_r;
  assign window_cmp_event = win_r;
  // with gain enabled the data pair is the window into the gain settings
  assign gain_write_word  = {high_r, low_r};
  // the gain bank sits outside this block, so no gain write strobe is raised here
  assign gain_write       = 1'b0;

  always_comb begin
    unique case (rpt_r)
      ara_pkg::ARA_RPT_1:  last_idx = 4'h0;
      ara_pkg::ARA_RPT_4:  last_idx = 4'h3;
      ara_pkg::ARA_RPT_8:  last_idx = 4'h7;
      ara_pkg::ARA_RPT_16: last_idx = 4'hF;
    endcase
  end

  assign sum_now = ((cnt_r == 4'h0) ? 16'h0000 : acc_r) + {{(16-RES_W){1'b0}}, conv_code};

  // full-scale 4 and 8 conversion sums carry one bit more than their high byte field;
  // the zero field bits win, so that top bit never shows in the data pair
  ara_format u_format (
    .sum       (sum_now),
    .rpt       (rpt_r),
    .ljst      (ljst_r),
    .high_byte (fmt_high),
    .low_byte  (fmt_low)
  );

  always_comb begin
    state_nxt = state_r;
    cfg_nxt   = cfg_r;
    ctrl_nxt  = ctrl_r;
    high_nxt  = high_r;
    low_nxt   = low_r;
    acc_nxt   = acc_r;
    cnt_nxt   = cnt_r;
    rpt_nxt   = rpt_r;
    ljst_nxt  = ljst_r;
    done_nxt  = 1'b0;
    win_nxt   = 1'b0;
    start_nxt = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        ara_pkg::ARA_CFG_ADDR:  cfg_nxt = bus.wdata;
        // busy reads back from the sequencer, so it is not stored
        ara_pkg::ARA_CTRL_ADDR: ctrl_nxt = bus.wdata & ~(8'h01 << ara_pkg::ARA_CTRL_BUSY_BIT);
        ara_pkg::ARA_HIGH_ADDR: high_nxt = bus.wdata;
        ara_pkg::ARA_LOW_ADDR:  low_nxt  = bus.wdata;
        default: ;
      endcase
    end
    // a core pulse outside a set is ignored, so a stray valid cannot touch the sum
    unique case (state_r)
      ARA_IDLE: begin
        if (trig) begin
          // settings are latched per set so a mid-set write cannot split the sum
          rpt_nxt   = cfg_r[ara_pkg::ARA_CFG_RPT_LSB +: 2];
          ljst_nxt  = ctrl_r[ara_pkg::ARA_CTRL_LJST_BIT];
          cnt_nxt   = 4'h0;
          start_nxt = 1'b1;
          state_nxt = ARA_CONV;
        end
      end
      ARA_CONV: begin
        if (conv_valid) begin
          acc_nxt = sum_now;
          if (cnt_r == last_idx) begin
            high_nxt  = fmt_high;
            low_nxt   = fmt_low;
            done_nxt  = 1'b1;
            win_nxt   = window_hit;
            ctrl_nxt[ara_pkg::ARA_CTRL_DONE_BIT] = 1'b1;
            if (window_hit) begin
              ctrl_nxt[ara_pkg::ARA_CTRL_WIN_BIT] = 1'b1;
            end
            cnt_nxt   = 4'h0;
            state_nxt = ARA_IDLE;
          end else begin
            cnt_nxt = cnt_r + 4'h1;
            if (burst) begin
              start_nxt = 1'b1;
            end else begin
              state_nxt = ARA_WAIT;
            end
          end
        end
      end
      ARA_WAIT: begin
        if (trig) begin
          start_nxt = 1'b1;
          state_nxt = ARA_CONV;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ARA_IDLE;
      cfg_r   <= ara_pkg::ARA_CFG_RESET;
      ctrl_r  <= ara_pkg::ARA_CTRL_RESET;
      high_r  <= ara_pkg::ARA_DATA_RESET;
      low_r   <= ara_pkg::ARA_DATA_RESET;
      acc_r   <= 16'h0000;
      cnt_r   <= 4'h0;
      rpt_r   <= ara_pkg::ARA_RPT_1;
      ljst_r  <= 1'b0;
      done_r  <= 1'b0;
      win_r   <= 1'b0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r   <= cfg_nxt;
      ctrl_r  <= ctrl_nxt;
      high_r  <= high_nxt;
      low_r   <= low_nxt;
      acc_r   <= acc_nxt;
      cnt_r   <= cnt_nxt;
      rpt_r   <= rpt_nxt;
      ljst_r  <= ljst_nxt;
      done_r  <= done_nxt;
      win_r   <= win_nxt;
      start_r <= start_nxt;
    end
  end

  // left justification with a repeat code other than 00 is software's to avoid
  // read mux is combinational; busy shows any set in progress
  always_comb begin
    unique case (bus.addr)
      ara_pkg::ARA_CFG_ADDR:  rdata = cfg_r;
      ara_pkg::ARA_CTRL_ADDR: rdata = ctrl_r | ({7'h00, state_r != ARA_IDLE} << ara_pkg::ARA_CTRL_BUSY_BIT);
      ara_pkg::ARA_HIGH_ADDR: rdata = high_r;
      ara_pkg::ARA_LOW_ADDR:  rdata = low_r;
      default:                rdata = 8'h00;
    endcase
  end
endmodule

// ==== ara_top_sva.sv ====
// port checker for the result accumulator top.
// assumes it is bound into ara_top from the bench.
`timescale 1ns/1ps
module ara_top_sva (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire ara_pkg::ara_bus_type bus,
  input wire logic [7:0]           rdata,
  input wire logic                 conv_start,
  input wire logic                 conv_valid,
  input wire logic                 conv_done_event,
  input wire logic                 window_cmp_event,
  input wire logic                 gain_prog_enable,
  input wire logic [15:0]          gain_write_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_win_with_done: assert property (window_cmp_event |-> conv_done_event)
    else $error("window event alone");
  a_done_after_valid: assert property (conv_done_event |-> $past(conv_valid))
    else $error("done without valid");
  a_done_spaced: assert property (conv_done_event |=> !conv_done_event [*2])
    else $error("done too close");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("start too long");
  a_gain_follow: assert property (bus.wr && bus.addr == ara_pkg::ARA_CFG_ADDR |=>
    gain_prog_enable == $past(bus.wdata[0])) else $error("gain bit wrong");
  a_high_read: assert property (bus.addr == ara_pkg::ARA_HIGH_ADDR |-> rdata == gain_write_word[15:8])
    else $error("high read wrong");
  a_low_read: assert property (bus.addr == ara_pkg::ARA_LOW_ADDR |-> rdata == gain_write_word[7:0])
    else $error("low read wrong");
  a_final_only: assert property ($changed(gain_write_word) |-> conv_done_event || $past(bus.wr))
    else $error("partial sum shown");
  c_done: cover property (conv_done_event);
  c_window: cover property (window_cmp_event);
  c_burst: cover property (conv_valid ##1 conv_start);
endmodule

// ==== ara_core_model.sv ====
// behavioural analog core: one valid pulse per start, fast or slow.
// assumes starts never overlap a conversion in flight.
`timescale 1ns/1ps
module ara_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        conv_start,
  input  wire logic        slow,
  input  wire logic [11:0] code,
  output logic             conv_valid,
  output logic [11:0]      conv_code
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (conv_start) cnt_nxt = slow ? 4'h7 : 4'h2;
    else if (cnt_r != 4'h0) cnt_nxt = cnt_r - 4'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 4'h0;
    else cnt_r <= cnt_nxt;
  end
  assign conv_valid = (cnt_r == 4'h1);
  // junk outside the pulse so a late sample cannot pass
  assign conv_code  = conv_valid ? code : ~code;
endmodule

// ==== ara_top_bench.sv ====
// self-checking bench for the result accumulator with a behavioural core.
// assumes ara_pkg, ara_top, ara_top_sva and ara_core_model compiled first.
`timescale 1ns/1ps
module ara_top_bench;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  ara_pkg::ara_bus_type bus = '0;
  logic                 start_trig = 1'b0;
  logic                 window_hit = 1'b0;
  logic                 slow = 1'b0;
  logic [11:0]          code = 12'hFFF;
  logic [11:0]          conv_code;
  logic [15:0]          gain_write_word;
  logic [7:0]           rdata;
  logic                 conv_start, conv_valid, conv_done_event, window_cmp_event, gain_prog_enable, gain_write;
  int                   err_total = 0, check_count = 0, nst = 0, nv = 0, nd = 0, nw = 0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    nst <= nst + int'(conv_start);
    nv  <= nv + int'(conv_valid);
    nd  <= nd + int'(conv_done_event);
    nw  <= nw + int'(window_cmp_event);
  end
  ara_top dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .start_trig(start_trig),
    .conv_start(conv_start), .conv_valid(conv_valid), .conv_code(conv_code), .window_hit(window_hit),
    .conv_done_event(conv_done_event), .window_cmp_event(window_cmp_event),
    .gain_prog_enable(gain_prog_enable), .gain_write_word(gain_write_word), .gain_write(gain_write));
  ara_core_model core (.clk(clk), .rst_n(rst_n), .conv_start(conv_start), .slow(slow), .code(code),
    .conv_valid(conv_valid), .conv_code(conv_code));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{1'b1, a, d};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus.addr <= a;
    @(negedge clk) chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  // trigger by pin, or by a control write when ctl is not zero
  task automatic set_run(input int n, input logic bst, input logic [7:0] ctl);
    int s0, d0, w0, v0, k;
    s0 = nst; d0 = nd; w0 = nw; v0 = nv;
    for (int i = 0; i < n; i++) begin
      if (!bst || i == 0) begin
        if (ctl != 8'h00) wr(ara_pkg::ARA_CTRL_ADDR, ctl);
        else begin
          @(posedge clk) start_trig <= 1'b1;
          @(posedge clk) start_trig <= 1'b0;
        end
      end
      k = 0;
      while (nv < v0 + i + 1 && k < 99) begin
        @(posedge clk);
        k++;
      end
    end
    repeat (3) @(posedge clk);
    chk("starts", 16'(n), 16'(nst - s0));
    chk("done", 16'h1, 16'(nd - d0));
    chk("window", {15'h0, window_hit}, 16'(nw - w0));
  endtask
  task automatic t_regs();
    rd(ara_pkg::ARA_CFG_ADDR, ara_pkg::ARA_CFG_RESET);
    rd(ara_pkg::ARA_CTRL_ADDR, 8'h00);
    rd(ara_pkg::ARA_HIGH_ADDR, 8'h00);
    wr(ara_pkg::ARA_CFG_ADDR, 8'hF9);
    @(negedge clk) chk("gain", 16'h1, {15'h0, gain_prog_enable});
    $display("test regs done");
  endtask
  // descending counts so a stale sum would show
  task automatic t_repeat();
    int n;
    logic [15:0] sum;
    // high byte field per repeat code 00..11; bits above the field read zero.
    // full-scale 4 and 8 sums overflow their field, so the zeroed bits are really tested
    logic [31:0] fld = 32'hFF3F1F0F;
    for (int r = 3; r >= 0; r--) begin
      n = (r == 0) ? 1 : 2 << r;
      sum = 16'(n * 4095);
      wr(ara_pkg::ARA_CFG_ADDR, 8'hF8 | 8'(r << 1));
      set_run(n, 1'b0, 8'h00);
      rd(ara_pkg::ARA_HIGH_ADDR, sum[15:8] & fld[r*8 +: 8]);
      rd(ara_pkg::ARA_LOW_ADDR, sum[7:0]);
    end
    $display("test repeat done");
  endtask
  task automatic t_burst();
    @(posedge clk) slow <= 1'b1;
    window_hit <= 1'b1;
    wr(ara_pkg::ARA_CTRL_ADDR, 8'h40);
    wr(ara_pkg::ARA_CFG_ADDR, 8'hFE);
    set_run(16, 1'b1, 8'h00);
    rd(ara_pkg::ARA_HIGH_ADDR, 8'hFF);
    rd(ara_pkg::ARA_LOW_ADDR, 8'hF0);
    @(posedge clk) window_hit <= 1'b0;
    $display("test burst done");
  endtask
  task automatic t_left();
    @(posedge clk) code <= 12'hABC;
    wr(ara_pkg::ARA_CFG_ADDR, 8'hF8);
    wr(ara_pkg::ARA_CTRL_ADDR, 8'h04);
    set_run(1, 1'b0, 8'h14);
    rd(ara_pkg::ARA_HIGH_ADDR, 8'hAB);
    rd(ara_pkg::ARA_LOW_ADDR, 8'hC0);
    rd(ara_pkg::ARA_CTRL_ADDR, 8'h24);
    chk("word", 16'hABC0, gain_write_word);
    chk("gain_write", 16'h0000, {15'h0, gain_write});
    $display("test left done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_repeat();
    t_burst();
    t_left();
    close_out();
  end
  // whole run is under 2000 cycles
  initial begin
    #400000;
    err_total++;
    close_out();
  end
endmodule
bind ara_top ara_top_sva u_sva (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .conv_start(conv_start),
  .conv_valid(conv_valid), .conv_done_event(conv_done_event), .window_cmp_event(window_cmp_event),
  .gain_prog_enable(gain_prog_enable), .gain_write_word(gain_write_word));
